/* File: host_slave_irq_and_local_bus_config_bench.sv */
// self-checking bench for the slave register set
`timescale 1ns/10ps
`default_nettype none
module host_slave_irq_and_local_bus_config_bench import slave_regs_pkg::*;;
  // ==================
  logic clk_sys = 0, arst_n = 0, soft_reset = 0, reg_wr = 0, reg_rd = 0, vector_push = 0;
  logic interrupt_overflow = 0, mailbox_write = 0, mst_req = 0, mst_write = 0;
  logic lbus_ds_mode = 0, local_interrupt_pin_in = 1;
  logic [8:0]  reg_addr = 0, queue_flags = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rq[$], fq[$], mq[$];
  logic [15:0] vector_word = 0, mst_wdata = 0, mst_rdata, local_data_lines_out;
  logic [15:0] local_data_lines_in, fr_wdata, fr_rdata, v[3];
  logic [1:0]  mst_page = 0;
  logic [12:0] mst_addr = 0;
  logic [14:0] lbus_addr;
  logic [4:0]  fr_port;
  logic [3:0]  fr_addr;
  logic reg_rvalid, pci_irq, lbi_flag, fifo_pending, local_interrupt_pin_out, vector_lost;
  logic local_interrupt_pin_oe_n, mst_ready, mst_done, lbus_req, lbus_grant, lbus_strobe;
  logic lbus_we, local_data_lines_oe_n, fr_wr, fr_rd;
  int fails = 0, total_checks = 0, i;
  slave_irq_lbus_cfg #(.INIT_COUNT(20), .FIFO_DEPTH(16), .MBOX_VECTOR(16'h8000)) i_dut (
    .clk_sys, .arst_n, .soft_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .interrupt_overflow, .queue_flags, .pci_irq, .lbi_flag, .fifo_pending,
    .local_interrupt_pin_in, .local_interrupt_pin_out, .local_interrupt_pin_oe_n,
    .vector_push, .vector_word, .mailbox_write, .vector_lost, .mst_req, .mst_write,
    .mst_page, .mst_addr, .mst_wdata, .mst_ready, .mst_done, .mst_rdata, .lbus_ds_mode,
    .lbus_req, .lbus_grant, .lbus_addr, .lbus_strobe, .lbus_we, .local_data_lines_out,
    .local_data_lines_oe_n, .local_data_lines_in, .fr_port, .fr_addr, .fr_wr, .fr_rd,
    .fr_wdata, .fr_rdata);
  lbus_far_end i_far (.clk_sys, .lbus_req, .lbus_strobe, .lbus_grant, .local_data_lines_in,
    .fr_rdata);
  initial forever #10 clk_sys = ~clk_sys;
  // ==================
  task automatic wrap_up;
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // reads note their expectation only when c is set, so polls stay unchecked
  task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d, input bit c);
    if (!w && c) rq.push_back(d);
    @(posedge clk_sys) #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys) #1;
    reg_wr = 0;
    reg_rd = 0;
  endtask
  task automatic pulse(input bit mb, input logic [15:0] w);
    @(posedge clk_sys) #1;
    mailbox_write = mb;
    vector_push = !mb;
    vector_word = w;
    @(posedge clk_sys) #1;
    mailbox_write = 0;
    vector_push = 0;
  endtask
  // ==================
  always @(posedge clk_sys) begin
    if (reg_rvalid === 1'b1 && rq.size() > 0) cmp(rq.pop_front(), reg_rdata);
    if (fr_wr === 1'b1) cmp(fq.pop_front(), {fr_port, fr_addr, fr_wdata});
    if (mst_done === 1'b1) cmp(mq.pop_front(), {lbus_addr, mst_rdata});
  end
  initial begin
    void'($urandom(32'h9147));
    repeat (12) @(posedge clk_sys);
    #1 arst_n = 1;
    acc(0, OFS_GLOBAL_INTERRUPT_MASK, GLOBAL_INTERRUPT_MASK_RST, 1);
    acc(0, OFS_FRAMER_LINK_CONFIGURATION, FRAMER_LINK_CONFIGURATION_RST, 1);
    acc(0, OFS_LOCAL_INTERRUPT_CONTROL, LOCAL_INTERRUPT_CONTROL_RST, 1);
    acc(0, OFS_IFIFO, FIFO_IDLE_WORD, 1);
    acc(0, 9'h0f8, 0, 1);
    i = 0;
    do begin
      acc(0, OFS_FRAMER_LINK_CONFIGURATION, 0, 0);
      i++;
    end while (reg_rdata[CF_IIP] !== 1'b0 && i < 60);
    if (reg_rdata[CF_IIP] !== 1'b0) begin
      fails++;
      wrap_up();
    end
    acc(1, OFS_FRAMER_LINK_CONFIGURATION, 32'hffff, 0);
    acc(0, OFS_FRAMER_LINK_CONFIGURATION, 32'h00ff, 1);
    v[0] = 16'($urandom);
    acc(1, OFS_LOCAL_MASTER_TIMER, {16'h0, v[0]}, 0);
    acc(0, OFS_LOCAL_MASTER_TIMER, {16'h0, v[0]}, 1);
    acc(1, OFS_TXSEL, 32'h5b8f, 0);
    fq = '{{5'h1b, 4'hf, 16'h1111}, {5'h00, 4'h0, 16'h2222}};
    acc(1, OFS_TXDATA, 32'h1111, 0);
    acc(1, OFS_TXDATA, 32'h2222, 0);
    acc(0, OFS_TXSEL, 32'h4181, 1);
    acc(0, OFS_TXDATA, 32'h5a3c, 1);
    pulse(1, 0);
    acc(0, OFS_IFIFO, FIFO_IDLE_WORD, 1);
    acc(1, OFS_FRAMER_LINK_CONFIGURATION, 32'h0000, 0);
    for (i = 0; i < 3; i++) v[i] = 16'($urandom);
    for (i = 0; i < 3; i++) pulse(0, v[i]);
    pulse(1, 0);
    for (i = 0; i < 3; i++) acc(0, OFS_IFIFO, {16'h0, v[i]}, 1);
    acc(0, OFS_IFIFO, 32'h8000, 1);
    pulse(0, v[0]);
    acc(1, OFS_LOCAL_INTERRUPT_CONTROL, 32'h0002, 0);
    acc(0, OFS_IFIFO, FIFO_IDLE_WORD, 1);
    // arbitrated read, three wait states, data-strobe mode with swapping
    acc(1, OFS_FRAMER_LINK_CONFIGURATION, 32'h0043, 0);
    acc(1, OFS_LOCAL_MASTER_TIMER, 32'h0013, 0);
    lbus_ds_mode = 1;
    mst_page = 2'h1;
    mst_addr = 13'($urandom);
    mq.push_back({mst_page, mst_addr, 16'h5ac3});
    @(posedge clk_sys) #1;
    mst_req = 1;
    @(posedge clk_sys) #1;
    mst_req = 0;
    repeat (30) @(posedge clk_sys);
    pulse(0, v[1]);
    @(posedge clk_sys) #1;
    cmp(3'b100, {fifo_pending, local_interrupt_pin_out, local_interrupt_pin_oe_n});
    acc(1, OFS_LOCAL_INTERRUPT_CONTROL, 32'h000c, 0);
    repeat (2) @(posedge clk_sys);
    #1 cmp(3'b101, {lbi_flag, local_interrupt_pin_out, local_interrupt_pin_oe_n});
    soft_reset = 1;
    @(posedge clk_sys) #1;
    soft_reset = 0;
    acc(0, OFS_FRAMER_LINK_CONFIGURATION, 32'h8043, 1);
    cmp(0, fifo_pending);
    acc(1, OFS_GLOBAL_INTERRUPT_MASK, 32'hfffffffe, 0);
    queue_flags = 9'($urandom) & 9'h1fe;
    repeat (3) @(posedge clk_sys);
    #1 cmp(0, pci_irq);
    queue_flags[0] = 1;
    repeat (3) @(posedge clk_sys);
    #1 cmp(1, pci_irq);
    // anything still queued means an expected result never appeared
    cmp(0, rq.size() + fq.size() + mq.size());
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: lbus_far_end.sv */
// far-side model: local bus arbiter, fixed bus read data and transmit framer read port
`timescale 1ns/10ps
`default_nettype none
module lbus_far_end (
  input  wire logic        clk_sys,
  input  wire logic        lbus_req,
  input  wire logic        lbus_strobe,
  output logic             lbus_grant,
  output logic      [15:0] local_data_lines_in,
  output logic      [15:0] fr_rdata
);
  // ==================
  // grant one cycle late so the arbitration wait is never zero
  always @(posedge clk_sys) lbus_grant <= lbus_req;
  // released lines show the inverse, never a stale copy of the last word
  assign local_data_lines_in = lbus_strobe ? 16'hc35a : 16'h3ca5;
  assign fr_rdata = 16'h5a3c;
endmodule
`default_nettype wire

/* File: slave_irq_lbus_cfg.sv */
// slave register set: interrupt gating, vector fifo, local master, tx framer window
`timescale 1ns/10ps
`default_nettype none

//
// Overview of operation
// - global mask gates each status flag; resets to its printed value, all masked except overflow bit 31
// - mask bit 31 suppresses overflow signalling on the pci interrupt
// - mask bit 17 zero forwards local interrupt input to pci interrupt
// - mask bit 16 zero lets a non-empty vector fifo raise pci interrupt
// - mask bits 8..0 gate queue interrupts only; vectors still written
// - after any reset, progress bit 15 stays one for about 250 us
// - with bit 7 zero, a mailbox write pushes a mailbox vector
// - configuration bit 6 makes strobe length come from wait-state field
// - in data-strobe mode, swap bytes on 16-bit transfers unless bit 5 set
// - bits 4..2 pick 8-bit or 16-bit mode per 8 kbyte page
// - bit 1 set: arbitrate for each access started from idle, not while the bus is held; clear: assume ownership
// - bit 0 zero keeps the block a local bus slave only
// - keep bus for first transaction or timer times 16 cycles
// - wait-state field sets cycles a strobe stays asserted
// - interrupt control bit 3 picks local interrupt pin direction
// - writing one to interrupt control bit 1 flushes the vector fifo
// - interrupt control bit 0 blocks fifo interrupt on the selected pin
// - vector fifo port returns 16-bit vectors, all ones when empty
// - select bit 14 increments port 0..27 after each data access
// - select bit 7 increments register address after each data access
// - data register accesses go to selected port and register only
// - each status flag drives pci interrupt only when unmasked
// - local interrupt input asserted sets bridge flag, and pci interrupt when mask bit 17 is zero
// - fifo flag reaches pci side only with pin input and mask clear
module slave_irq_lbus_cfg import slave_regs_pkg::*; #(
  parameter int              INIT_COUNT  = INIT_CYCLES,
  parameter int              FIFO_DEPTH  = 16,
  parameter logic [15:0]     MBOX_VECTOR = 16'h8000
) (
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          soft_reset,
  input  wire logic [8:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [31:0]   reg_wdata,
  output logic      [31:0]   reg_rdata,
  output logic               reg_rvalid,
  input  wire logic          interrupt_overflow,
  input  wire logic [8:0]    queue_flags,
  output logic               pci_irq,
  output logic               lbi_flag,
  output logic               fifo_pending,
  input  wire logic          local_interrupt_pin_in,
  output logic               local_interrupt_pin_out,
  output logic               local_interrupt_pin_oe_n,
  input  wire logic          vector_push,
  input  wire logic [15:0]   vector_word,
  input  wire logic          mailbox_write,
  output logic               vector_lost,
  input  wire logic          mst_req,
  input  wire logic          mst_write,
  input  wire logic [1:0]    mst_page,
  input  wire logic [12:0]   mst_addr,
  input  wire logic [15:0]   mst_wdata,
  output logic               mst_ready,
  output logic               mst_done,
  output logic      [15:0]   mst_rdata,
  input  wire logic          lbus_ds_mode,
  output logic               lbus_req,
  input  wire logic          lbus_grant,
  output logic      [14:0]   lbus_addr,
  output logic               lbus_strobe,
  output logic               lbus_we,
  output logic      [15:0]   local_data_lines_out,
  output logic               local_data_lines_oe_n,
  input  wire logic [15:0]   local_data_lines_in,
  output logic      [4:0]    fr_port,
  output logic      [3:0]    fr_addr,
  output logic               fr_wr,
  output logic               fr_rd,
  output logic      [15:0]   fr_wdata,
  input  wire logic [15:0]   fr_rdata
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int IW = $clog2(INIT_COUNT + 1);
  localparam logic [IW-1:0] INIT_LOAD = IW'(INIT_COUNT);

  // ==========================================================================
  // register storage
  logic [31:0]   global_interrupt_mask_reg;
  logic [15:0]   framer_link_configuration_reg;
  logic [15:0]   local_master_timer_reg;
  logic [15:0]   local_interrupt_control_reg;
  logic [15:0]   txsel_reg;
  logic [IW-1:0] init_cnt_reg;
  logic          init_busy;

  logic wr_global_interrupt_mask, wr_framer_link_configuration, wr_local_master_timer, wr_local_interrupt_control, wr_txsel, acc_txdata, rd_fifo;
  assign wr_global_interrupt_mask   = reg_wr && (reg_addr == OFS_GLOBAL_INTERRUPT_MASK);
  assign wr_framer_link_configuration   = reg_wr && (reg_addr == OFS_FRAMER_LINK_CONFIGURATION);
  assign wr_local_master_timer  = reg_wr && (reg_addr == OFS_LOCAL_MASTER_TIMER);
  assign wr_local_interrupt_control = reg_wr && (reg_addr == OFS_LOCAL_INTERRUPT_CONTROL);
  assign wr_txsel   = reg_wr && (reg_addr == OFS_TXSEL);
  assign acc_txdata = (reg_wr || reg_rd) && (reg_addr == OFS_TXDATA);
  assign rd_fifo    = reg_rd && (reg_addr == OFS_IFIFO);
  assign init_busy  = (init_cnt_reg != '0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      global_interrupt_mask_reg   <= GLOBAL_INTERRUPT_MASK_RST;
      framer_link_configuration_reg   <= FRAMER_LINK_CONFIGURATION_RST & FRAMER_LINK_CONFIGURATION_WMASK;
      local_master_timer_reg  <= LOCAL_MASTER_TIMER_RST;
      local_interrupt_control_reg <= LOCAL_INTERRUPT_CONTROL_RST;
    end else begin
      if (wr_global_interrupt_mask)   global_interrupt_mask_reg   <= reg_wdata;
      if (wr_framer_link_configuration)   framer_link_configuration_reg   <= reg_wdata[15:0] & FRAMER_LINK_CONFIGURATION_WMASK;
      if (wr_local_master_timer)  local_master_timer_reg  <= reg_wdata[15:0];
      // the flush bit is an action, so it never stays stored
      if (wr_local_interrupt_control) local_interrupt_control_reg <= reg_wdata[15:0] & LOCAL_INTERRUPT_CONTROL_WMASK;
    end
  end

  // ram self-initialisation after hardware or software reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      init_cnt_reg <= INIT_LOAD;
    end else if (soft_reset) begin
      init_cnt_reg <= INIT_LOAD;
    end else if (init_busy) begin
      init_cnt_reg <= init_cnt_reg - IW'(1);
    end
  end

  // ==========================================================================
  // interrupt vector fifo
  logic [15:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [PW:0]   fill_reg;
  logic          mbox_pend_reg;
  logic          fifo_empty, fifo_full, do_push, do_pop, flush;
  logic [15:0]   push_word;

  assign fifo_empty = (fill_reg == '0);
  assign fifo_full  = (fill_reg == (PW+1)'(FIFO_DEPTH));
  assign flush      = (wr_local_interrupt_control && reg_wdata[IC_FLUSH]) || soft_reset;
  // framer vectors go first; a mailbox vector waits for a cycle without a framer push instead of being lost
  assign push_word  = vector_push ? vector_word : MBOX_VECTOR;
  assign do_push    = (vector_push || mbox_pend_reg) && !fifo_full && !flush;
  assign do_pop     = rd_fifo && !fifo_empty && !flush;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mbox_pend_reg <= 1'b0;
    end else if (mailbox_write && !framer_link_configuration_reg[CF_MAILBOX_VECTOR_DISABLE]) begin
      mbox_pend_reg <= 1'b1;
    end else if (flush || (do_push && !vector_push)) begin
      mbox_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      fifo_mem[wr_ptr_reg] <= push_word;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      fill_reg    <= '0;
      vector_lost <= 1'b0;
    end else begin
      vector_lost <= vector_push && fifo_full && !flush;
      if (flush) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        fill_reg   <= '0;
      end else begin
        if (do_push) wr_ptr_reg <= (wr_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
        if (do_pop)  rd_ptr_reg <= (rd_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
        fill_reg <= fill_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
    end
  end

  // ==========================================================================
  // interrupt pins
  logic local_interrupt_pin_in_reg, local_interrupt_pin_active, fifo_irq;
  assign local_interrupt_pin_active = local_interrupt_control_reg[IC_ID] && (local_interrupt_pin_in_reg == local_interrupt_control_reg[IC_IP]);
  assign fifo_irq    = !fifo_empty && !local_interrupt_control_reg[IC_IM];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      local_interrupt_pin_in_reg              <= 1'b0;
      lbi_flag                 <= 1'b0;
      fifo_pending             <= 1'b0;
      pci_irq                  <= 1'b0;
      local_interrupt_pin_out  <= 1'b0;
      local_interrupt_pin_oe_n <= 1'b1;
    end else begin
      local_interrupt_pin_in_reg  <= local_interrupt_pin_in;
      lbi_flag     <= local_interrupt_pin_active;
      fifo_pending <= !fifo_empty;
      pci_irq <= (interrupt_overflow && !global_interrupt_mask_reg[GM_OVF])
               || (local_interrupt_pin_active && !global_interrupt_mask_reg[GM_LBI])
               || (fifo_irq && local_interrupt_control_reg[IC_ID] && !global_interrupt_mask_reg[GM_IF])
               || (|(queue_flags & ~global_interrupt_mask_reg[GM_Q_HI:0]));
      local_interrupt_pin_oe_n <= local_interrupt_control_reg[IC_ID];
      // an idle output sits at the inactive level of the chosen polarity
      local_interrupt_pin_out  <= (fifo_irq && !local_interrupt_control_reg[IC_ID])
                                  ? local_interrupt_control_reg[IC_IP] : !local_interrupt_control_reg[IC_IP];
    end
  end

  // ==========================================================================
  // transmit framer indirect window
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txsel_reg <= TXSEL_RST;
      fr_wr     <= 1'b0;
      fr_rd     <= 1'b0;
      fr_wdata  <= TXDATA_RST;
    end else begin
      fr_wr <= acc_txdata && reg_wr;
      fr_rd <= acc_txdata && !reg_wr;
      if (acc_txdata && reg_wr) fr_wdata <= reg_wdata[15:0];
      if (wr_txsel) begin
        txsel_reg <= reg_wdata[15:0] & TXSEL_WMASK;
      end else if (acc_txdata) begin
        if (txsel_reg[SEL_AIP])
          txsel_reg[SEL_PT_HI:SEL_PT_LO] <= (txsel_reg[SEL_PT_HI:SEL_PT_LO] >= PORT_LAST)
                                            ? '0 : txsel_reg[SEL_PT_HI:SEL_PT_LO] + 5'h01;
        if (txsel_reg[SEL_AIA])
          txsel_reg[SEL_AD_HI:0] <= txsel_reg[SEL_AD_HI:0] + 4'h1;
      end
    end
  end

  // strobes come one cycle after the access, so port and address lag the same way
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fr_port <= '0;
      fr_addr <= '0;
    end else if (acc_txdata || !(fr_wr || fr_rd)) begin
      fr_port <= txsel_reg[SEL_PT_HI:SEL_PT_LO];
      fr_addr <= txsel_reg[SEL_AD_HI:0];
    end
  end

  // ==========================================================================
  // register read port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == OFS_GLOBAL_INTERRUPT_MASK)        reg_rdata <= global_interrupt_mask_reg;
        else if (reg_addr == OFS_FRAMER_LINK_CONFIGURATION)   reg_rdata <= {16'h0000, init_busy, framer_link_configuration_reg[14:0]};
        else if (reg_addr == OFS_LOCAL_MASTER_TIMER)  reg_rdata <= {16'h0000, local_master_timer_reg};
        else if (reg_addr == OFS_LOCAL_INTERRUPT_CONTROL) reg_rdata <= {16'h0000, local_interrupt_control_reg};
        else if (reg_addr == OFS_IFIFO)   reg_rdata <= {16'h0000,
                                           fifo_empty ? FIFO_IDLE_WORD : fifo_mem[rd_ptr_reg]};
        else if (reg_addr == OFS_TXSEL)   reg_rdata <= {16'h0000, txsel_reg};
        else if (reg_addr == OFS_TXDATA)  reg_rdata <= {16'h0000, fr_rdata};
        else                              reg_rdata <= '0;
      end
    end
  end

  // ==========================================================================
  // local bus master
  master_state_t state_reg;
  logic [3:0]    strobe_cnt_reg;
  logic [15:0]   lat_cnt_reg;
  logic          cur_narrow_reg, cur_swap_reg;
  logic          narrow_sel, swap_sel, start_ok;
  logic [3:0]    strobe_len;
  logic [15:0]   lat_load;

  assign narrow_sel = (int'(mst_page) < PAGE_COUNT) && framer_link_configuration_reg[CF_PG_LO + int'(mst_page)];
  assign swap_sel   = lbus_ds_mode && !framer_link_configuration_reg[CF_BSD] && !narrow_sel;
  assign strobe_len = (framer_link_configuration_reg[CF_WSE] && (local_master_timer_reg[MT_WS_HI:0] != '0))
                      ? local_master_timer_reg[MT_WS_HI:0] : STROBE_PLAIN;
  assign lat_load   = {local_master_timer_reg[MT_TM_HI:MT_TM_LO], LAT_SHIFT'(0)};
  assign start_ok   = mst_req && mst_ready && framer_link_configuration_reg[CF_LME] && !init_busy;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg             <= ST_IDLE;
      strobe_cnt_reg        <= '0;
      lat_cnt_reg           <= '0;
      cur_narrow_reg        <= 1'b0;
      cur_swap_reg          <= 1'b0;
      mst_ready             <= 1'b1;
      mst_done              <= 1'b0;
      mst_rdata             <= '0;
      lbus_req              <= 1'b0;
      lbus_addr             <= '0;
      lbus_strobe           <= 1'b0;
      lbus_we               <= 1'b0;
      local_data_lines_out  <= '0;
      local_data_lines_oe_n <= 1'b1;
    end else begin
      mst_done <= 1'b0;
      if (lat_cnt_reg != '0) lat_cnt_reg <= lat_cnt_reg - 16'h0001;
      case (state_reg)
        ST_IDLE, ST_HOLD: begin
          if (start_ok) begin
            mst_ready      <= 1'b0;
            cur_narrow_reg <= narrow_sel;
            cur_swap_reg   <= swap_sel;
            lbus_addr      <= {mst_page, mst_addr};
            lbus_we        <= mst_write;
            local_data_lines_out <= narrow_sel ? {8'h00, mst_wdata[7:0]}
                                  : swap_sel ? {mst_wdata[7:0], mst_wdata[15:8]} : mst_wdata;
            if (framer_link_configuration_reg[CF_LAE] && state_reg == ST_IDLE) begin
              lbus_req  <= 1'b1;
              state_reg <= ST_ARB;
            end else begin
              lbus_strobe           <= 1'b1;
              local_data_lines_oe_n <= !mst_write;
              strobe_cnt_reg        <= strobe_len;
              state_reg             <= ST_STROBE;
            end
          end else if (state_reg == ST_HOLD && lat_cnt_reg == '0) begin
            lbus_req  <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_ARB: begin
          if (lbus_grant) begin
            lat_cnt_reg           <= lat_load;
            lbus_strobe           <= 1'b1;
            local_data_lines_oe_n <= !lbus_we;
            strobe_cnt_reg        <= strobe_len;
            state_reg             <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (strobe_cnt_reg == 4'h1) begin
            lbus_strobe           <= 1'b0;
            local_data_lines_oe_n <= 1'b1;
            mst_done              <= 1'b1;
            mst_ready             <= 1'b1;
            mst_rdata <= cur_narrow_reg ? {8'h00, local_data_lines_in[7:0]}
                       : cur_swap_reg ? {local_data_lines_in[7:0], local_data_lines_in[15:8]}
                       : local_data_lines_in;
            if (lbus_req && lat_cnt_reg > 16'h0001) begin
              state_reg <= ST_HOLD;
            end else begin
              lbus_req  <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end else begin
            strobe_cnt_reg <= strobe_cnt_reg - 4'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_ovf_masked: assert property (global_interrupt_mask_reg[GM_OVF] && queue_flags == '0 && !local_interrupt_pin_active
      && !(fifo_irq && local_interrupt_control_reg[IC_ID]) |=> !pci_irq)
    else $error("masked overflow reached pci interrupt");
  chk_queue_irq: assert property ((queue_flags & ~global_interrupt_mask_reg[GM_Q_HI:0]) != '0 |=> pci_irq)
    else $error("unmasked queue flag did not raise pci interrupt");
  chk_bridge_flag: assert property (local_interrupt_pin_active && !global_interrupt_mask_reg[GM_LBI] |=> pci_irq && lbi_flag)
    else $error("bridged local interrupt not forwarded");
  chk_fifo_flush: assert property (wr_local_interrupt_control && reg_wdata[IC_FLUSH] |=> fifo_empty)
    else $error("flush left vectors in fifo");
  chk_fifo_idle: assert property (rd_fifo && fifo_empty |=> reg_rdata[15:0] == FIFO_IDLE_WORD)
    else $error("empty fifo read not all ones");
  chk_mbox_vector: assert property (mailbox_write && framer_link_configuration_reg[CF_MAILBOX_VECTOR_DISABLE] && !mbox_pend_reg
      |=> !mbox_pend_reg)
    else $error("mailbox vector made while disabled");
  chk_slave_only: assert property (!framer_link_configuration_reg[CF_LME] && state_reg == ST_IDLE
      |=> state_reg == ST_IDLE)
    else $error("master started while disabled");
  chk_strobe_len: assert property ($rose(lbus_strobe) && framer_link_configuration_reg[CF_WSE]
      && local_master_timer_reg[MT_WS_HI:0] == 4'h3 && $stable(local_master_timer_reg)
      |-> lbus_strobe [*3] ##1 !lbus_strobe)
    else $error("strobe length differs from wait states");
  chk_port_wrap: assert property (acc_txdata && !wr_txsel && txsel_reg[SEL_AIP]
      && txsel_reg[SEL_PT_HI:SEL_PT_LO] == PORT_LAST |=> txsel_reg[SEL_PT_HI:SEL_PT_LO] == '0)
    else $error("port auto increment did not wrap");
  chk_init_bit: assert property (soft_reset |=> init_busy [*8])
    else $error("progress bit cleared too early");
  chk_arb_req: assert property (start_ok && framer_link_configuration_reg[CF_LAE] && state_reg == ST_IDLE
      |=> lbus_req && !lbus_strobe)
    else $error("access started without arbitration");

endmodule

`default_nettype wire

/* File: slave_regs_pkg.sv */
// constants of the slave register set: offsets, fields, reset values, timing
package slave_regs_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [8:0] OFS_GLOBAL_INTERRUPT_MASK   = 9'h0f4;
  localparam logic [8:0] OFS_FRAMER_LINK_CONFIGURATION   = 9'h100;
  localparam logic [8:0] OFS_LOCAL_MASTER_TIMER  = 9'h104;
  localparam logic [8:0] OFS_LOCAL_INTERRUPT_CONTROL = 9'h108;
  localparam logic [8:0] OFS_IFIFO   = 9'h10c;
  localparam logic [8:0] OFS_TXSEL   = 9'h110;
  localparam logic [8:0] OFS_TXDATA  = 9'h114;

  // ==========================================================================
  // reset values and writable bits
  localparam logic [31:0] GLOBAL_INTERRUPT_MASK_RST      = 32'h0fffffff;
  localparam logic [15:0] FRAMER_LINK_CONFIGURATION_RST      = 16'h8080;
  localparam logic [15:0] FRAMER_LINK_CONFIGURATION_WMASK    = 16'h00ff;
  localparam logic [15:0] LOCAL_MASTER_TIMER_RST     = 16'h0000;
  localparam logic [15:0] LOCAL_INTERRUPT_CONTROL_RST    = 16'h0001;
  localparam logic [15:0] LOCAL_INTERRUPT_CONTROL_WMASK  = 16'h000d;
  localparam logic [15:0] FIFO_IDLE_WORD = 16'hffff;
  localparam logic [15:0] TXSEL_RST      = 16'h0000;
  localparam logic [15:0] TXSEL_WMASK    = 16'h5f8f;
  localparam logic [15:0] TXDATA_RST     = 16'h0000;

  // ==========================================================================
  // field positions
  localparam int GM_OVF    = 31;
  localparam int GM_LBI    = 17;
  localparam int GM_IF     = 16;
  localparam int GM_Q_HI   = 8;
  localparam int CF_IIP    = 15;
  localparam int CF_MAILBOX_VECTOR_DISABLE   = 7;
  localparam int CF_WSE    = 6;
  localparam int CF_BSD    = 5;
  localparam int CF_PG_LO  = 2;
  localparam int CF_LAE    = 1;
  localparam int CF_LME    = 0;
  localparam int MT_TM_HI  = 15;
  localparam int MT_TM_LO  = 4;
  localparam int MT_WS_HI  = 3;
  localparam int IC_ID     = 3;
  localparam int IC_IP     = 2;
  localparam int IC_FLUSH  = 1;
  localparam int IC_IM     = 0;
  localparam int SEL_AIP   = 14;
  localparam int SEL_PT_HI = 12;
  localparam int SEL_PT_LO = 8;
  localparam int SEL_AIA   = 7;
  localparam int SEL_AD_HI = 3;

  // ==========================================================================
  // counts and timing
  localparam logic [4:0]  PORT_LAST     = 5'h1b;
  localparam logic [3:0]  STROBE_PLAIN  = 4'h1;
  localparam int          LAT_SHIFT     = 4;    // latency timer counts in units of 16
  localparam int          PAGE_COUNT    = 3;
  localparam int          INIT_TIME_US  = 250;
  localparam int          CLK_MHZ       = 50;
  localparam int          INIT_CYCLES   = INIT_TIME_US * CLK_MHZ;

  // ==========================================================================
  // local bus master states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ARB    = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD   = 4'b1000
  } master_state_t;

endpackage
